// File: src/smc_pkg.sv
// shared constants and helpers for the strap-configured microstep driver and its host
// How it works
// R1 - pdn strap low: reduce current at standstill
// R2 - pdn strap high: no standstill reduction
// R3 - serial mode ignores strap; host programs hold
// R4 - resolution straps pick 8, 32, 64, 16
// R5 - leaving standby restores all register defaults
// R6 - host stops, disables, lowers pins before standby
// R7 - fullstep every n steps, first at n/2
// R8 - fullstep counter values 128, 384, 640, 896
// R9 - power-up clears registers and position counter
// R10 - counter zero every four fullsteps
// R11 - each step moves counter 256/resolution
// R12 - direction low counts upward
// R13 - host can read the microstep counter
// R14 - host restores position with steps before enabling
// R15 - enable low stops stage, clears error flags
// R16 - ten-bit counter wraps modulo 1024
package smc_pkg;

   localparam int          CNT_W          = 10;
   localparam int          CUR_W          = 5;
   localparam logic [7:0]  FULLSTEP_LOW8  = 8'h80;

   // resolution strap code is {high, low}
   localparam logic [1:0]  RES_8          = 2'h0;
   localparam logic [1:0]  RES_32         = 2'h1;
   localparam logic [1:0]  RES_64         = 2'h2;
   localparam logic [1:0]  RES_16         = 2'h3;

   localparam logic [4:0]  RUN_CURRENT    = 5'h1F;
   localparam logic [4:0]  AUTO_HOLD_CUR  = 5'h0F;

   // host register map, byte offsets
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_STEPS      = 8'h04;
   localparam logic [7:0]  REG_RESTORE    = 8'h08;
   localparam logic [7:0]  REG_STATUS     = 8'h0C;
   localparam logic [7:0]  REG_CNT_RD     = 8'h10;
   localparam logic [7:0]  REG_HOLD       = 8'h14;

   // control register fields
   localparam int          CTRL_W         = 7;
   localparam int          CTRL_EN        = 0;
   localparam int          CTRL_DIR       = 1;
   localparam int          CTRL_RES_LOW   = 2;
   localparam int          CTRL_RES_HIGH  = 3;
   localparam int          CTRL_PDN       = 4;
   localparam int          CTRL_SERIAL    = 5;
   localparam int          CTRL_POWERED   = 6;
   localparam logic [6:0]  CTRL_RESET     = 7'h40;

   // status register fields
   localparam int          STAT_BUSY      = 0;
   localparam int          STAT_CNT_FRESH = 1;
   localparam int          STAT_SUPPLY    = 2;
   localparam int          STAT_CNT_LSB   = 16;

   // timing
   localparam int          CLK_NS         = 10;
   localparam int          STEP_HIGH_NS   = 100;
   localparam int          STEP_LOW_NS    = 100;
   localparam int          STEP_HIGH_CYC  = (STEP_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int          STEP_LOW_CYC   = (STEP_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int          STANDSTILL_US  = 200000;
   localparam int          STANDSTILL_CYC = STANDSTILL_US * (1000 / CLK_NS);

   // counter increment per step pulse, 256 / microsteps
   function automatic logic [CNT_W-1:0] smc_step_size(input logic [1:0] code);
      unique case (code)
         RES_8:   smc_step_size = 10'h020;
         RES_32:  smc_step_size = 10'h008;
         RES_64:  smc_step_size = 10'h004;
         RES_16:  smc_step_size = 10'h010;
      endcase
   endfunction : smc_step_size

   // mask for position modulo four times the resolution
   function automatic logic [15:0] smc_period_mask(input logic [1:0] code);
      unique case (code)
         RES_8:   smc_period_mask = 16'h001F;
         RES_32:  smc_period_mask = 16'h007F;
         RES_64:  smc_period_mask = 16'h00FF;
         RES_16:  smc_period_mask = 16'h003F;
      endcase
   endfunction : smc_period_mask

endpackage : smc_pkg

// File: src/smc_link_if.sv
// pin-level link between host controller and driver
`timescale 1ns/1ps
interface smc_link_if;
   logic       step;
   logic       dir;
   logic       enable;
   logic       res_low;
   logic       res_high;
   logic       serial_mode;
   logic       io_supply;
   logic       pdn_o;
   logic       pdn_oe;
   logic       pdn_level;
   logic       hold_wr;
   logic [4:0] hold_data;
   logic       cnt_rd_req;
   logic       cnt_rd_valid;
   logic [9:0] cnt_rd_data;

   // pull-up when nobody drives the shared pin
   assign pdn_level = pdn_oe ? pdn_o : 1'b1;

   modport host (
      output step, dir, enable, res_low, res_high, serial_mode, io_supply,
      output pdn_o, pdn_oe, hold_wr, hold_data, cnt_rd_req,
      input  pdn_level, cnt_rd_valid, cnt_rd_data
   );

   modport driver (
      input  step, dir, enable, res_low, res_high, serial_mode, io_supply,
      input  pdn_level, hold_wr, hold_data, cnt_rd_req,
      output cnt_rd_valid, cnt_rd_data
   );
endinterface : smc_link_if

// File: src/smc_step_counter.sv
// ten-bit microstep position counter with fullstep marker
`timescale 1ns/1ps
module smc_step_counter
   import smc_pkg::*;
(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_clear,
   // step input
   input  wire logic             i_step_pulse,
   input  wire logic             i_dir,
   input  wire logic [1:0]       i_res_code,
   // position
   output logic      [CNT_W-1:0] o_count,
   output logic                  o_fullstep
);
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic             full_next;
   wire  [CNT_W-1:0] step_size = smc_step_size(i_res_code);  // [R4] [R11]

   // natural wrap of ten bits gives zero every four fullsteps
   assign count_next = i_clear      ? '0 :                   // [R9]
                       !i_step_pulse ? count_reg :
                       i_dir         ? count_reg - step_size // down when high
                                     : count_reg + step_size; // [R12] [R16] [R10]
   // from zero, n/2 steps land on 128; then every n steps adds 256
   assign full_next  = (count_next[7:0] == FULLSTEP_LOW8);   // [R7] [R8]

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count_reg  <= '0;
         o_fullstep <= 1'b0;
      end else begin
         count_reg  <= count_next;
         o_fullstep <= full_next;
      end
   end

   assign o_count = count_reg;
endmodule : smc_step_counter

// File: src/smc_driver.sv
// driver end: strap decode, standstill reduction, enable, error latch, position count
`timescale 1ns/1ps
module smc_driver
   import smc_pkg::*;
#(
   parameter int STANDSTILL_CYCLES = STANDSTILL_CYC
)(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // link to host
   smc_link_if.driver            link,
   // power stage side
   input  wire logic             i_error_event,
   output logic                  o_stage_on,
   output logic                  o_hold_reduce,
   output logic      [CUR_W-1:0] o_coil_current,
   output logic                  o_error_latched,
   // position
   output logic      [CNT_W-1:0] o_microstep_count,
   output logic                  o_fullstep
);
   localparam int               IDLE_W   = $clog2(STANDSTILL_CYCLES + 1);
   localparam logic [IDLE_W-1:0] IDLE_MAX = IDLE_W'(STANDSTILL_CYCLES - 1);

   logic              step_prev_reg;
   logic [IDLE_W-1:0] idle_reg;
   logic [IDLE_W-1:0] idle_next;
   logic [CUR_W-1:0]  hold_setting_reg;
   logic [CUR_W-1:0]  current_next;
   logic              reduce_next;
   logic              error_next;

   // standby drops all state back to power-up values
   wire standby_clr  = ~link.io_supply;                       // [R5] [R9]
   wire step_pulse   = link.step & ~step_prev_reg;
   wire standstill   = (idle_reg == IDLE_MAX);
   // strap only counts in standalone; low level asks for reduction
   wire auto_reduce  = ~link.serial_mode & ~link.pdn_level;   // [R1] [R2] [R3]

   assign idle_next    = (standby_clr | step_pulse) ? '0 :
                         standstill ? idle_reg : idle_reg + 1'b1;
   assign reduce_next  = standstill & (link.serial_mode | auto_reduce);
   assign current_next = (standstill & link.serial_mode) ? hold_setting_reg : // [R3]
                         (standstill & auto_reduce)      ? AUTO_HOLD_CUR     : // [R1]
                                                           RUN_CURRENT;       // [R2]
   // enable low holds errors clear as long as it stays low
   assign error_next   = link.enable & (o_error_latched | i_error_event); // [R15]

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         step_prev_reg    <= 1'b0;
         idle_reg         <= '0;
         hold_setting_reg <= '0;
         o_stage_on       <= 1'b0;
         o_hold_reduce    <= 1'b0;
         o_coil_current   <= '0;
         o_error_latched  <= 1'b0;
         link.cnt_rd_valid <= 1'b0;
         link.cnt_rd_data  <= '0;
      end else if (standby_clr) begin                          // [R5]
         step_prev_reg    <= 1'b0;
         idle_reg         <= '0;
         hold_setting_reg <= '0;
         o_stage_on       <= 1'b0;
         o_hold_reduce    <= 1'b0;
         o_coil_current   <= '0;
         o_error_latched  <= 1'b0;
         link.cnt_rd_valid <= 1'b0;
         link.cnt_rd_data  <= '0;
      end else begin
         step_prev_reg    <= link.step;
         idle_reg         <= idle_next;
         if (link.hold_wr & link.serial_mode) begin
            hold_setting_reg <= link.hold_data;                // [R3]
         end
         o_stage_on       <= link.enable;                      // [R15]
         o_hold_reduce    <= reduce_next;
         o_coil_current   <= link.enable ? current_next : '0;  // [R15]
         o_error_latched  <= error_next;
         link.cnt_rd_valid <= link.cnt_rd_req;                 // [R13]
         link.cnt_rd_data  <= o_microstep_count;               // [R13]
      end
   end

   // steps count even with the stage off, so position can be restored
   smc_step_counter u_counter (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_clear      (standby_clr),
      .i_step_pulse (step_pulse),
      .i_dir        (link.dir),
      .i_res_code   ({link.res_high, link.res_low}),
      .o_count      (o_microstep_count),
      .o_fullstep   (o_fullstep)
   );
endmodule : smc_driver

// File: src/smc_host.sv
// host end: register port, step train, restore and standby sequencing
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module smc_host
   import smc_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // software register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // link to driver
   smc_link_if.host         link
);
   typedef enum logic [1:0] {
      SMC_ST_IDLE = 2'b00,
      SMC_ST_HIGH = 2'b01,
      SMC_ST_LOW  = 2'b10
   } smc_state_t;

   localparam logic [7:0] HIGH_LAST = 8'(STEP_HIGH_CYC - 1);
   localparam logic [7:0] LOW_LAST  = 8'(STEP_LOW_CYC - 1);

   smc_state_t          state_reg;
   smc_state_t          state_next;
   logic [CTRL_W-1:0]   ctrl_reg;
   logic [15:0]         remain_reg;
   logic [15:0]         remain_next;
   logic [7:0]          phase_reg;
   logic [7:0]          phase_next;
   logic                restoring_reg;
   logic                pins_down_reg;
   logic                cnt_fresh_reg;
   logic [CNT_W-1:0]    last_cnt_reg;
   logic [31:0]         rd_mux;

   wire        busy        = (state_reg != SMC_ST_IDLE);
   wire        powered     = ctrl_reg[CTRL_POWERED];
   wire        serial      = ctrl_reg[CTRL_SERIAL];
   wire [1:0]  res_code    = {ctrl_reg[CTRL_RES_HIGH], ctrl_reg[CTRL_RES_LOW]};
   wire        wr_ctrl     = i_wr & (i_addr == REG_CTRL);
   wire        wr_steps    = i_wr & (i_addr == REG_STEPS) & ~busy & powered;
   wire        wr_restore  = i_wr & (i_addr == REG_RESTORE) & ~busy & powered;
   wire        wr_cnt_rd   = i_wr & (i_addr == REG_CNT_RD) & powered;
   wire        wr_hold     = i_wr & (i_addr == REG_HOLD) & serial & powered;
   wire        rd_status   = i_rd & (i_addr == REG_STATUS);
   // pins go low only once the step train has finished
   wire        shutdown    = ~powered & ~busy;                          // [R6]
   wire [15:0] restore_cnt = i_wdata[15:0] & smc_period_mask(res_code); // [R14]
   wire        restore_nxt = wr_restore | (restoring_reg & (state_next != SMC_ST_IDLE));

   always_comb begin
      state_next  = state_reg;
      remain_next = remain_reg;
      phase_next  = phase_reg;
      unique case (state_reg)
         SMC_ST_IDLE: begin
            remain_next = wr_steps ? i_wdata[15:0] : wr_restore ? restore_cnt : remain_reg;
            if ((wr_steps && i_wdata[15:0] != '0) || (wr_restore && restore_cnt != '0)) begin
               state_next = SMC_ST_HIGH;
               phase_next = HIGH_LAST;
            end
         end
         SMC_ST_HIGH: begin
            phase_next = phase_reg - 1'b1;
            if (phase_reg == '0) begin
               state_next  = SMC_ST_LOW;
               phase_next  = LOW_LAST;
               remain_next = remain_reg - 1'b1;
            end
         end
         SMC_ST_LOW: begin
            phase_next = phase_reg - 1'b1;
            if (phase_reg == '0) begin
               state_next = (remain_reg == '0) ? SMC_ST_IDLE : SMC_ST_HIGH;
               phase_next = HIGH_LAST;
            end
         end
         default: begin
            state_next = SMC_ST_IDLE;
         end
      endcase
   end

   assign rd_mux = (i_addr == REG_CTRL)   ? {25'h0, ctrl_reg} :
                   (i_addr == REG_STATUS) ? {6'h0, last_cnt_reg, 13'h0, link.io_supply,
                                             cnt_fresh_reg, busy} :
                   (i_addr == REG_HOLD)   ? {27'h0, link.hold_data} : 32'h0;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg     <= SMC_ST_IDLE;
         ctrl_reg      <= CTRL_RESET;
         remain_reg    <= '0;
         phase_reg     <= '0;
         restoring_reg <= 1'b0;
         pins_down_reg <= 1'b0;
         cnt_fresh_reg <= 1'b0;
         last_cnt_reg  <= '0;
         o_rdata       <= '0;
      end else begin
         state_reg     <= state_next;
         remain_reg    <= remain_next;
         phase_reg     <= phase_next;
         restoring_reg <= restore_nxt;
         pins_down_reg <= shutdown;
         if (wr_ctrl) begin
            ctrl_reg <= i_wdata[CTRL_W-1:0];
         end
         if (link.cnt_rd_valid) begin
            last_cnt_reg <= link.cnt_rd_data;                                 // [R13]
         end
         // a new answer wins over a status read clearing the flag
         cnt_fresh_reg <= link.cnt_rd_valid | (cnt_fresh_reg & ~rd_status);
         o_rdata       <= i_rd ? rd_mux : 32'h0;
      end
   end

   // link pins, all from flops
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         link.step        <= 1'b0;
         link.dir         <= 1'b0;
         link.enable      <= 1'b0;
         link.res_low     <= 1'b0;
         link.res_high    <= 1'b0;
         link.serial_mode <= 1'b0;
         link.io_supply   <= 1'b0;
         link.pdn_o       <= 1'b0;
         link.pdn_oe      <= 1'b0;
         link.hold_wr     <= 1'b0;
         link.hold_data   <= '0;
         link.cnt_rd_req  <= 1'b0;
      end else begin
         link.step        <= (state_next == SMC_ST_HIGH);
         link.dir         <= ~shutdown & ~restore_nxt & ctrl_reg[CTRL_DIR];     // [R14]
         // driver stays off until restore steps are done
         link.enable      <= ~shutdown & ~restore_nxt & ctrl_reg[CTRL_EN];      // [R14] [R6]
         link.res_low     <= ~shutdown & ctrl_reg[CTRL_RES_LOW];                // [R6]
         link.res_high    <= ~shutdown & ctrl_reg[CTRL_RES_HIGH];
         link.serial_mode <= ~shutdown & serial;
         // supply drops one cycle after the pins went low
         link.io_supply   <= ~(shutdown & pins_down_reg);                       // [R6]
         link.pdn_o       <= ~shutdown & ctrl_reg[CTRL_PDN];
         link.pdn_oe      <= shutdown | ~serial;
         link.hold_wr     <= wr_hold;                                           // [R3]
         link.hold_data   <= wr_hold ? i_wdata[CUR_W-1:0] : link.hold_data;
         link.cnt_rd_req  <= wr_cnt_rd;                                         // [R13]
      end
   end
endmodule : smc_host

// File: sim/smc_chk.sv
// assertions on the host-driver link and the driver's position outputs
`timescale 1ns/1ps
module smc_chk #(
   parameter int STANDSTILL_CYCLES = 20
)(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // link signals
   input  wire logic       step,
   input  wire logic       dir,
   input  wire logic       enable,
   input  wire logic       res_low,
   input  wire logic       res_high,
   input  wire logic       serial_mode,
   input  wire logic       io_supply,
   input  wire logic       pdn_o,
   input  wire logic       pdn_oe,
   input  wire logic       pdn_level,
   input  wire logic       cnt_rd_req,
   input  wire logic       cnt_rd_valid,
   // driver outputs
   input  wire logic       o_stage_on,
   input  wire logic       o_hold_reduce,
   input  wire logic       o_error_latched,
   input  wire logic [9:0] o_microstep_count,
   input  wire logic       o_fullstep
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   wire logic [9:0] stride = res_high ? (res_low ? 10'h010 : 10'h004)
                                      : (res_low ? 10'h008 : 10'h020);
   int              idle_reg;

   // idle time only counts while reduction is allowed, so a late strap change cannot fire it
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) idle_reg <= 0;
      else if (step || serial_mode || pdn_level || !enable || !io_supply) idle_reg <= 0;
      else if (idle_reg < STANDSTILL_CYCLES + 4) idle_reg <= idle_reg + 1;
   end

   rd_answer_a: assert property (cnt_rd_req |=> cnt_rd_valid)
      else $error("counter read not answered");
   count_stride_a: assert property ($changed(o_microstep_count) && io_supply && $past(io_supply)
      |-> 10'(o_microstep_count - $past(o_microstep_count)) == ($past(dir) ? 10'(0 - stride) : stride))
      else $error("counter moved by wrong stride");
   fullstep_mark_a: assert property (o_fullstep == (o_microstep_count[7:0] == 8'h80))
      else $error("fullstep mark disagrees with counter");
   standby_clear_a: assert property (!io_supply |=> o_microstep_count == 10'h000)
      else $error("counter not cleared in standby");
   standby_pins_a: assert property ($fell(io_supply)
      |-> !(step || dir || enable || res_low || res_high) && pdn_oe && !pdn_o)
      else $error("pin high when supply removed");
   stage_off_a: assert property (!enable |=> !o_stage_on && !o_error_latched)
      else $error("stage or error flag alive with enable low");
   no_reduce_a: assert property ((!serial_mode && pdn_level)[*2] |=> !o_hold_reduce)
      else $error("reduction with strap high");
   auto_reduce_a: assert property (idle_reg == STANDSTILL_CYCLES + 4 |-> o_hold_reduce)
      else $error("no reduction at standstill");
   step_high_a: assert property ($rose(step) |-> step[*8] ##1 step ##1 step ##1 !step)
      else $error("step pulse width wrong");

   cover property (o_fullstep);
   cover property (o_hold_reduce);
   cover property ($fell(io_supply));
endmodule : smc_chk

// File: sim/smc_bench.sv
// bench: host and driver joined by the link, against a step-count model
`timescale 1ns/1ps
module smc_bench
   import smc_pkg::*;
;
   localparam int    SS = 20;
   logic             i_clk = 1'b0;
   logic             i_sys_rst = 1'b1;
   logic [7:0]       i_addr = 8'h00;
   logic [31:0]      i_wdata = 32'h0000_0000;
   logic             i_wr = 1'b0;
   logic             i_rd = 1'b0;
   logic             i_error_event = 1'b0;
   logic [31:0]      o_rdata;
   logic [31:0]      rd_val;
   logic             o_stage_on, o_hold_reduce, o_error_latched, o_fullstep;
   logic [CUR_W-1:0] o_coil_current;
   logic [CNT_W-1:0] o_microstep_count;
   logic [7:0]       lf = 8'h51;
   logic [1:0]       code = 2'h0;
   logic             sdir = 1'b0;
   int               fails = 0, compares = 0, cycles = 0, model = 0;
   int               stride [4] = '{32, 8, 4, 16};

   always #5 i_clk = ~i_clk;

   smc_link_if link();
   smc_host smc_host_i (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .link(link));
   smc_driver #(.STANDSTILL_CYCLES(SS)) smc_driver_i (.i_clk, .i_sys_rst, .link(link),
      .i_error_event, .o_stage_on, .o_hold_reduce, .o_coil_current, .o_error_latched,
      .o_microstep_count, .o_fullstep);
   smc_chk #(.STANDSTILL_CYCLES(SS)) smc_chk_i (.i_clk, .i_sys_rst, .step(link.step),
      .dir(link.dir), .enable(link.enable), .res_low(link.res_low), .res_high(link.res_high),
      .serial_mode(link.serial_mode), .io_supply(link.io_supply), .pdn_o(link.pdn_o),
      .pdn_oe(link.pdn_oe), .pdn_level(link.pdn_level), .cnt_rd_req(link.cnt_rd_req),
      .cnt_rd_valid(link.cnt_rd_valid), .o_stage_on, .o_hold_reduce, .o_error_latched,
      .o_microstep_count, .o_fullstep);

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr

   task automatic print_verdict();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 rd_val = o_rdata;
   endtask : rd

   task automatic ctrl(input logic en, input logic pdn, input logic ser, input logic pwr);
      wr(REG_CTRL, {25'h0, pwr, ser, pdn, code, sdir, en});
   endtask : ctrl

   task automatic wait_idle();
      rd_val = 32'h0000_0001;
      for (int i = 0; i < 500 && rd_val[STAT_BUSY] !== 1'b0; i++) begin
         rd(REG_STATUS);
      end
      chk(rd_val[STAT_BUSY] === 1'b0, "busy stuck");
   endtask : wait_idle

   task automatic steps(input int n);
      wr(REG_STEPS, 32'(n));
      wait_idle();
      model = (model + 4096 + (sdir ? -n : n) * stride[code]) % 1024;
   endtask : steps

   task automatic cnt_check();
      wr(REG_CNT_RD, 32'h0000_0000);
      repeat (3) @(posedge i_clk);
      rd(REG_STATUS);
      chk(rd_val[25:16] === 10'(model), "counter readback");
      chk(rd_val[STAT_CNT_FRESH] === 1'b1 && rd_val[STAT_SUPPLY] === 1'b1, "status flags");
      rd(REG_STATUS);
      chk(rd_val[STAT_CNT_FRESH] === 1'b0, "fresh flag kept after read");
      chk(o_microstep_count === 10'(model), "counter value");
   endtask : cnt_check

   // supply off and on again; the counter must come back from zero
   task automatic standby();
      ctrl(1'b0, 1'b1, 1'b0, 1'b0);
      repeat (6) @(posedge i_clk);
      chk(link.io_supply === 1'b0 && link.enable === 1'b0, "standby pins");
      chk(o_microstep_count === 10'h000, "standby clear");
      model = 0;
      ctrl(1'b1, 1'b1, 1'b0, 1'b1);
   endtask : standby

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         print_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(REG_CTRL);
      chk(rd_val[6:0] === CTRL_RESET, "ctrl reset value");
      rd(8'h3C);
      chk(rd_val === 32'h0000_0000, "unmapped read");
      for (int k = 0; k < 8; k++) begin
         code = k[1:0];
         sdir = k[2];
         ctrl(1'b1, 1'b1, 1'b0, 1'b1);
         lf = lfsr(lf);
         steps(int'(lf[4:0]) + 1);
         cnt_check();
      end
      code = RES_32;
      sdir = 1'b0;
      standby();
      steps(15);
      chk(o_fullstep === 1'b0, "early fullstep");
      steps(1);
      for (int k = 0; k < 4; k++) begin
         chk(o_fullstep === 1'b1 && o_microstep_count === 10'(128 + 256 * k), "fullstep");
         if (k < 3) steps(32);
      end
      steps(16);
      chk(o_microstep_count === 10'h000, "four fullstep wrap");
      // direction set high so the restore has to force it low
      sdir = 1'b1;
      standby();
      wr(REG_RESTORE, 32'h0000_050A);
      repeat (3) @(posedge i_clk);
      chk(link.enable === 1'b0, "enabled during restore");
      chk(link.dir === 1'b0, "direction not forced low in restore");
      wait_idle();
      model = (1290 % (4 * 32)) * 8;
      cnt_check();
      chk(link.enable === 1'b1, "enable not returned");
      ctrl(1'b1, 1'b0, 1'b0, 1'b1);
      repeat (SS + 10) @(posedge i_clk);
      chk(o_hold_reduce === 1'b1 && o_coil_current === AUTO_HOLD_CUR, "auto hold");
      ctrl(1'b1, 1'b1, 1'b0, 1'b1);
      repeat (4) @(posedge i_clk);
      chk(o_hold_reduce === 1'b0 && o_coil_current === RUN_CURRENT, "strap high");
      wr(REG_HOLD, 32'h0000_001E);
      rd(REG_HOLD);
      chk(rd_val === 32'h0000_0000, "hold taken outside serial");
      ctrl(1'b1, 1'b0, 1'b1, 1'b1);
      lf = lfsr(lf);
      // even values never match the run or auto-hold current
      wr(REG_HOLD, {27'h0, lf[4:1], 1'b0});
      repeat (SS + 10) @(posedge i_clk);
      chk(o_coil_current === {lf[4:1], 1'b0}, "serial hold setting");
      rd(REG_HOLD);
      chk(rd_val === {27'h0, lf[4:1], 1'b0}, "hold readback");
      ctrl(1'b1, 1'b1, 1'b0, 1'b1);
      i_error_event <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_error_event <= 1'b0;
      chk(o_error_latched === 1'b1 && o_stage_on === 1'b1, "error latch");
      ctrl(1'b0, 1'b1, 1'b0, 1'b1);
      repeat (3) @(posedge i_clk);
      chk(o_error_latched === 1'b0 && o_stage_on === 1'b0 && o_coil_current === 5'h00,
          "enable low");
      print_verdict();
   end
endmodule : smc_bench
